// >>> hdl/exec_pkg.sv
// Package: register map, command layout, opcodes, flags and timing for the execution unit
package exec_pkg;
    // Register byte offsets on the APB side
    localparam logic [7:0] CMD_OFS = 8'h00;
    localparam logic [7:0] ACC_OFS = 8'h04;
    localparam logic [7:0] STAT_OFS = 8'h08;
    localparam logic [7:0] PC_OFS = 8'h0C;
    localparam logic [7:0] WDT_OFS = 8'h10;
    localparam logic [7:0] MEM_OFS = 8'h40;
    // Data memory geometry
    localparam int MEM_WORDS = 16;
    localparam int MEM_AW = 4;
    // Program counter and stack geometry
    localparam int PC_W = 12;
    localparam int STACK_DEPTH = 4;
    localparam int SP_W = 2;
    // Reset values, clear byte and program counter step
    localparam logic [7:0] ACC_RST = 8'h00;
    localparam logic [PC_W-1:0] PC_RST = 12'h000;
    localparam logic [7:0] CLEAR_BYTE = 8'h00;
    localparam logic [PC_W-1:0] PC_STEP = 12'h001;
    // Timing: one watchdog tick per microsecond, watchdog period in ms
    localparam int CLK_MHZ = 100;
    localparam int TICK_US = 1;
    localparam int TICK_CYCLES = CLK_MHZ * TICK_US;
    localparam int WDT_TIME_MS = 1;
    localparam int WDT_TICKS = (WDT_TIME_MS * 1000) / TICK_US;
    localparam int TICK_W = 7;
    localparam int WDT_W = 16;

    // Instruction codes carried in the low nibble of the command word
    typedef enum logic [3:0] {
        OP_NOP = 4'h0,
        OP_ADD_MEM = 4'h1,
        OP_AND_ACC = 4'h2,
        OP_AND_IMM = 4'h3,
        OP_AND_MEM = 4'h4,
        OP_CALL = 4'h5,
        OP_CLR_BYTE = 4'h6,
        OP_CLR_BIT = 4'h7,
        OP_WDT_RESTART = 4'h8
    } op_e;

    // Command word as written to the command register
    typedef struct packed {
        logic [3:0] spare_hi;
        logic [PC_W-1:0] target;   // Call target; low byte is the immediate
        logic [4:0] spare_lo;
        logic [2:0] bit_sel;
        logic [MEM_AW-1:0] addr;
        op_e op;
    } cmd_s;

    // Status flags, bit 6 downward in the status register
    typedef struct packed {
        logic sleep_entry_flag;
        logic watchdog_expiry_flag;
        logic signed_borrow_flag;
        logic carry_flag;
        logic half_carry_flag;
        logic zero_flag;
        logic arith_sign_error_flag;
    } flags_s;
    localparam flags_s FLAGS_RST = 7'h00;

    // Result bundle from the ALU
    typedef struct packed {
        logic [7:0] value;
        logic to_mem;
        logic to_acc;
        flags_s flags;
    } alu_out_s;
endpackage

// >>> hdl/exec_alu.sv
// Combinational ALU: computes the result and new flags of one instruction
`timescale 1ns/100ps
`default_nettype none
module exec_alu
    import exec_pkg::*;
(
    input wire op_e op,
    input wire logic [7:0] acc_in,
    input wire logic [7:0] mem_in,
    input wire logic [7:0] imm,
    input wire logic [2:0] bit_sel,
    input wire flags_s flags_in,
    output var alu_out_s res
);
    logic [8:0] sum9;      // Full sum with carry out
    logic [4:0] half5;     // Low nibble sum for half carry
    logic [7:0] bit_mask;  // One-hot mask of the selected bit

    // Result and flag selection per instruction
    always_comb begin
        sum9 = {1'b0, acc_in} + {1'b0, mem_in};
        half5 = {1'b0, acc_in[3:0]} + {1'b0, mem_in[3:0]};
        bit_mask = 8'h01 << bit_sel;
        res.value = CLEAR_BYTE;
        res.to_mem = 1'b0;
        res.to_acc = 1'b0;
        // Flags not touched below carry over unchanged
        res.flags = flags_in;
        case (op)
            OP_ADD_MEM: begin
                res.value = sum9[7:0];
                res.to_mem = 1'b1;
                res.flags.carry_flag = sum9[8];
                res.flags.half_carry_flag = half5[4];
                res.flags.zero_flag = (sum9[7:0] == CLEAR_BYTE);
                res.flags.arith_sign_error_flag = (acc_in[7] == mem_in[7])
                    && (sum9[7] != acc_in[7]);
                // Sign of the true result: overflow flips the stored sign
                res.flags.signed_borrow_flag = res.flags.arith_sign_error_flag
                    ^ sum9[7];
            end
            OP_AND_ACC: begin
                res.value = acc_in & mem_in;
                res.to_acc = 1'b1;
                res.flags.zero_flag = (res.value == CLEAR_BYTE);
            end
            OP_AND_IMM: begin
                res.value = acc_in & imm;
                res.to_acc = 1'b1;
                res.flags.zero_flag = (res.value == CLEAR_BYTE);
            end
            OP_AND_MEM: begin
                res.value = acc_in & mem_in;
                res.to_mem = 1'b1;
            end
            OP_CLR_BYTE: begin
                res.value = CLEAR_BYTE;
                res.to_mem = 1'b1;
            end
            OP_CLR_BIT: begin
                res.value = mem_in & ~bit_mask;
                res.to_mem = 1'b1;
            end
            default: begin
                // Call, watchdog restart and no-op do not touch data or flags
                res.value = CLEAR_BYTE;
            end
        endcase
    end
endmodule
`default_nettype wire

// >>> hdl/exec_unit.sv
// Execution unit: APB-reached core running data, call and watchdog instructions
// What this block does
// - Add working register into memory byte, five flags
// - AND memory into working register, zero flag
// - AND immediate into working register, zero flag
// - AND working register into memory byte
// - Call pushes PC plus one, loads target
// - Call takes two instruction cycles
// - Clear byte writes zero, flags kept
// - Clear bit zeroes one bit only
// - Watchdog restart clears counter and two flags
`timescale 1ns/100ps
`default_nettype none
module exec_unit
    import exec_pkg::*;
#(
    parameter int WDT_LIMIT = WDT_TICKS  // Watchdog period in ticks
)
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic sleep_enter,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic call_busy
);
    logic [7:0] mem [MEM_WORDS];              // Data memory
    logic [PC_W-1:0] stack [STACK_DEPTH];     // Hardware return stack
    logic [SP_W-1:0] sp;                      // Next free stack slot
    logic [7:0] working_register;             // Accumulator
    flags_s flags;                            // Status flags
    logic [PC_W-1:0] pc;                      // Program counter
    logic [PC_W-1:0] call_target;             // Target held for the second call cycle
    logic [TICK_W-1:0] tick_cnt;              // Divider to the watchdog tick
    logic tick;                               // One-cycle tick enable
    logic [WDT_W-1:0] watchdog_counter;       // Watchdog tick count
    logic wdt_expire;                         // Counter reached its limit
    logic sleep_q1;                           // Sleep request synchroniser, stage 1
    logic sleep_q2;                           // Sleep request synchroniser, stage 2
    logic sleep_q3;                           // Delayed copy for edge detection
    logic access;                             // Access phase
    logic wr_done;                            // Write takes effect this edge
    logic exec_go;                            // Command write accepted
    cmd_s cmd;                                // Command word from the bus
    alu_out_s alu;                            // ALU result
    logic mem_hit;                            // Address falls in data memory
    logic [MEM_AW-1:0] mem_idx;               // Word index into data memory
    logic map_hit;                            // Address is mapped
    logic [31:0] next_rdata;                  // Read mux output

    // Byte offset to data memory index
    function automatic logic [MEM_AW-1:0] word_index(input logic [7:0] a);
        word_index = a[MEM_AW+1:2];
    endfunction

    assign access = psel && penable;
    assign wr_done = access && pready && pwrite;
    assign cmd = cmd_s'(pwdata);
    assign exec_go = wr_done && (paddr == CMD_OFS);
    assign mem_hit = (paddr >= MEM_OFS) && (paddr < MEM_OFS + 8'(4 * MEM_WORDS))
        && (paddr[1:0] == 2'b00);
    assign mem_idx = word_index(paddr);

    exec_alu u_alu (
        .op(cmd.op),
        .acc_in(working_register),
        .mem_in(mem[cmd.addr]),
        .imm(cmd.target[7:0]),
        .bit_sel(cmd.bit_sel),
        .flags_in(flags),
        .res(alu)
    );

    // Address decode and read mux; unmapped addresses read zero
    always_comb begin
        map_hit = 1'b1;
        next_rdata = 32'h0000_0000;
        if (paddr == CMD_OFS) begin
            next_rdata = 32'h0000_0000;
        end else if (paddr == ACC_OFS) begin
            next_rdata = {24'h00_0000, working_register};
        end else if (paddr == STAT_OFS) begin
            next_rdata = {25'h000_0000, flags};
        end else if (paddr == PC_OFS) begin
            next_rdata = {20'h0_0000, pc};
        end else if (paddr == WDT_OFS) begin
            next_rdata = {16'h0000, watchdog_counter};
        end else if (mem_hit) begin
            next_rdata = {24'h00_0000, mem[mem_idx]};
        end else begin
            map_hit = 1'b0;
        end
    end

    // APB answer: one wait state; held off while a call finishes
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (access && !pready && !call_busy) begin
            pready <= 1'b1;
            prdata <= pwrite ? 32'h0000_0000 : next_rdata;
            pslverr <= !map_hit;
        end else begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    // Call sequencing: second cycle loads the target
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            call_busy <= 1'b0;
            call_target <= PC_RST;
        end else begin
            call_busy <= exec_go && (cmd.op == OP_CALL);
            if (exec_go) begin
                call_target <= cmd.target;
            end
        end
    end

    // Program counter and return stack
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pc <= PC_RST;
            sp <= '0;
            for (int i = 0; i < STACK_DEPTH; i++) begin
                stack[i] <= PC_RST;
            end
        end else if (call_busy) begin
            pc <= call_target;
        end else if (exec_go) begin
            if (cmd.op == OP_CALL) begin
                // Push the return address; a full stack wraps over its oldest entry
                stack[sp] <= pc + PC_STEP;
                sp <= sp + 1'b1;
            end
            pc <= pc + PC_STEP;
        end else if (wr_done && paddr == PC_OFS) begin
            pc <= pwdata[PC_W-1:0];
        end
    end

    // Data memory: instruction results and direct bus writes
    always_ff @(posedge clock) begin
        if (exec_go && alu.to_mem) begin
            mem[cmd.addr] <= alu.value;
        end else if (wr_done && mem_hit) begin
            mem[mem_idx] <= pwdata[7:0];
        end
    end

    // Working register
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            working_register <= ACC_RST;
        end else if (exec_go && alu.to_acc) begin
            working_register <= alu.value;
        end else if (wr_done && paddr == ACC_OFS) begin
            working_register <= pwdata[7:0];
        end
    end

    // Sleep request comes from a pin, so it is synchronised first
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sleep_q1 <= 1'b0;
            sleep_q2 <= 1'b0;
            sleep_q3 <= 1'b0;
        end else begin
            sleep_q1 <= sleep_enter;
            sleep_q2 <= sleep_q1;
            sleep_q3 <= sleep_q2;
        end
    end

    // Flags: ALU result on execute; expiry and sleep events win over the restart clear
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            flags <= FLAGS_RST;
        end else begin
            if (exec_go) begin
                flags <= alu.flags;
                if (cmd.op == OP_WDT_RESTART) begin
                    flags.watchdog_expiry_flag <= 1'b0;
                    flags.sleep_entry_flag <= 1'b0;
                end
            end else if (wr_done && paddr == STAT_OFS) begin
                flags[4:0] <= pwdata[4:0];
            end
            if (wdt_expire) begin
                flags.watchdog_expiry_flag <= 1'b1;
            end
            if (sleep_q2 && !sleep_q3) begin
                flags.sleep_entry_flag <= 1'b1;
            end
        end
    end

    // Tick divider and watchdog counter; the restart clears both
    assign tick = (tick_cnt == TICK_W'(TICK_CYCLES - 1));
    assign wdt_expire = tick && (watchdog_counter == WDT_W'(WDT_LIMIT - 1));
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            tick_cnt <= '0;
            watchdog_counter <= '0;
        end else if (exec_go && cmd.op == OP_WDT_RESTART) begin
            tick_cnt <= '0;
            watchdog_counter <= '0;
        end else begin
            tick_cnt <= tick ? '0 : tick_cnt + 1'b1;
            if (wdt_expire) begin
                watchdog_counter <= '0;
            end else if (tick) begin
                watchdog_counter <= watchdog_counter + 1'b1;
            end
        end
    end

    // Helper copies of the executed command for the checks below
    // Expiry and sleep events may set the top two flags at any edge, so checks mask them
    logic [7:0] chk_acc;
    logic [7:0] chk_mem;
    flags_s chk_flags;
    always_ff @(posedge clock) begin
        chk_acc <= working_register;
        chk_mem <= mem[cmd.addr];
        chk_flags <= flags;
    end

    sequence call_issue_s;
        exec_go && cmd.op == OP_CALL;
    endsequence
    sequence call_finish_s;
        call_busy ##1 !call_busy;
    endsequence

    // Checks compare with copies taken at the execute edge, i.e. pre-instruction values

    add_to_mem_a: assert property (@(posedge clock) disable iff (!rst_n)
        exec_go && cmd.op == OP_ADD_MEM |=>
        mem[$past(cmd.addr)] == 8'(chk_acc + chk_mem))
        else $error("memory add result wrong");
    add_flags_a: assert property (@(posedge clock) disable iff (!rst_n)
        exec_go && cmd.op == OP_ADD_MEM |=>
        flags.carry_flag == ((9'(chk_acc) + 9'(chk_mem)) > 9'h0FF)
        && flags.half_carry_flag == ((5'(chk_acc[3:0]) + 5'(chk_mem[3:0])) > 5'h0F)
        && flags.zero_flag == (8'(chk_acc + chk_mem) == 8'h00))
        else $error("memory add flags wrong");
    and_acc_a: assert property (@(posedge clock) disable iff (!rst_n)
        exec_go && cmd.op == OP_AND_ACC |=>
        working_register == (chk_acc & chk_mem)
        && flags.zero_flag == ((chk_acc & chk_mem) == 8'h00)
        && flags.carry_flag == chk_flags.carry_flag)
        else $error("and into working register wrong");
    and_imm_a: assert property (@(posedge clock) disable iff (!rst_n)
        exec_go && cmd.op == OP_AND_IMM |=>
        working_register == (chk_acc & $past(cmd.target[7:0])))
        else $error("and immediate wrong");
    imm_zero_a: assert property (@(posedge clock) disable iff (!rst_n)
        exec_go && cmd.op == OP_AND_IMM |=>
        flags.zero_flag == ((chk_acc & $past(cmd.target[7:0])) == 8'h00)
        && flags[4:2] == chk_flags[4:2] && flags[0] == chk_flags[0])
        else $error("and immediate zero flag wrong");
    and_mem_a: assert property (@(posedge clock) disable iff (!rst_n)
        exec_go && cmd.op == OP_AND_MEM |=>
        mem[$past(cmd.addr)] == (chk_acc & chk_mem) && working_register == chk_acc)
        else $error("and into memory wrong");
    call_push_a: assert property (@(posedge clock) disable iff (!rst_n)
        call_issue_s |=> stack[sp - 1'b1] == $past(pc) + PC_STEP
        ##1 pc == $past(call_target) && flags[4:0] == chk_flags[4:0])
        else $error("call push or target load wrong");
    call_two_a: assert property (@(posedge clock) disable iff (!rst_n)
        call_issue_s |=> call_finish_s)
        else $error("call does not take two cycles");
    clr_byte_a: assert property (@(posedge clock) disable iff (!rst_n)
        exec_go && cmd.op == OP_CLR_BYTE |=> mem[$past(cmd.addr)] == 8'h00
        && flags[4:0] == chk_flags[4:0])
        else $error("clear byte wrong");
    clr_bit_a: assert property (@(posedge clock) disable iff (!rst_n)
        exec_go && cmd.op == OP_CLR_BIT |=> mem[$past(cmd.addr)]
        == (chk_mem & ~(8'h01 << $past(cmd.bit_sel))))
        else $error("clear bit wrong");
    wdt_clear_a: assert property (@(posedge clock) disable iff (!rst_n)
        exec_go && cmd.op == OP_WDT_RESTART && !wdt_expire |=>
        watchdog_counter == 16'h0000 && !flags.watchdog_expiry_flag)
        else $error("watchdog restart wrong");
    sleep_clear_a: assert property (@(posedge clock) disable iff (!rst_n)
        exec_go && cmd.op == OP_WDT_RESTART && !(sleep_q2 && !sleep_q3) |=>
        !flags.sleep_entry_flag)
        else $error("restart left the sleep flag set");
    flag_keep_a: assert property (@(posedge clock) disable iff (!rst_n)
        exec_go && (cmd.op == OP_AND_MEM || cmd.op == OP_CLR_BIT) |=>
        flags[4:0] == chk_flags[4:0])
        else $error("unlisted flag changed");
endmodule
`default_nettype wire

// >>> testbench/apb_host.sv
// Bus partner: APB requester standing in for the software side of the core
`timescale 1ns/100ps
`default_nettype none
module apb_host (
    input wire logic clock,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata
);
    // Bus idle from time zero, so nothing is requested while reset is low
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
    end

    // One whole transfer: setup, then access held until pready is seen at a rising edge
    task automatic xfer(input logic wr, input logic [7:0] addr, input logic [31:0] data,
                        output logic [31:0] rd, output logic err, output logic ok);
        int n;
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= data;
        @(posedge clock);
        penable <= 1'b1;
        n = 0;
        // Bounded wait, so a core that never answers cannot hang the run
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 20);
        ok = (pready === 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // Stale write data is inverted so the core cannot lean on a held value
        pwdata <= ~data;
    endtask
endmodule
`default_nettype wire

// >>> testbench/mcu_instruction_semantics_bench.sv
// Testbench: random and corner-case instruction runs through the APB port
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) bad(nm, 32'(e), 32'(g)); end
module mcu_instruction_semantics_bench import exec_pkg::*;;
    logic clock;
    logic rst_n;
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
    logic sleep_enter;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic call_busy;
    int err_total;
    int n_checks;

    // Short watchdog period keeps the expiry wait at a few hundred cycles
    exec_unit #(.WDT_LIMIT(3)) u_dut (
        .clock(clock),
        .rst_n(rst_n),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .sleep_enter(sleep_enter),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .call_busy(call_busy)
    );

    // Software side of the register port
    apb_host u_host (
        .clock(clock),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata)
    );

    // 100 MHz system clock
    always #5 clock = ~clock;

    // Mismatch report
    task automatic bad(input string nm, input logic [31:0] e, input logic [31:0] g);
        err_total++;
        $display("BAD %s expected %0h seen %0h", nm, e, g);
    endtask

    // Verdict and end of run
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Register access to a mapped place; a lost answer ends the run
    task automatic rw(input logic wr, input logic [7:0] ad, input logic [31:0] d,
                      output logic [31:0] rd);
        logic e;
        logic ok;
        u_host.xfer(wr, ad, d, rd, e, ok);
        if (ok !== 1'b1) begin
            bad("apb_answer", 32'h1, 32'h0);
            report_and_stop();
        end
        `CHK("slverr", 1'b0, e)
    endtask

    // Expected effect of one data instruction on working register, byte and flags 4..0
    function automatic void model(input logic [3:0] op, input logic [7:0] imm,
                                  input logic [2:0] bn, inout logic [7:0] ac,
                                  inout logic [7:0] mv, inout logic [4:0] fl);
        logic [8:0] s;
        logic ov;
        s = {1'b0, ac} + {1'b0, mv};
        ov = (ac[7] == mv[7]) && (s[7] != ac[7]);
        case (op)
            4'h1: begin
                fl = {ov ^ s[7], s[8], ({1'b0, ac[3:0]} + {1'b0, mv[3:0]}) > 5'h0F,
                      s[7:0] == 8'h00, ov};
                mv = s[7:0];
            end
            4'h2: begin
                ac = ac & mv;
                fl[1] = (ac == 8'h00);
            end
            4'h3: begin
                ac = ac & imm;
                fl[1] = (ac == 8'h00);
            end
            4'h4: mv = ac & mv;
            4'h6: mv = 8'h00;
            4'h7: mv[bn] = 1'b0;
            default: ; // Nop and unknown codes touch no data
        endcase
    endfunction

    // Main sequence
    initial begin
        logic [31:0] q;
        logic [7:0] a;
        logic [7:0] m;
        logic [7:0] ma;
        logic [4:0] f;
        logic [11:0] pcv;
        logic e;
        logic ok;
        cmd_s c;
        logic [3:0] ops [8];
        clock = 1'b0;
        rst_n = 1'b0;
        sleep_enter = 1'b0;
        err_total = 0;
        n_checks = 0;
        ops = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h6, 4'h7, 4'hF};
        void'($urandom(32'hEC53));
        repeat (2) @(posedge clock);
        rst_n <= 1'b1;
        // Reset values
        rw(1'b0, ACC_OFS, 32'h0, q);
        `CHK("acc_rst", 8'h00, q[7:0])
        rw(1'b0, STAT_OFS, 32'h0, q);
        `CHK("stat_rst", 7'h00, q[6:0])
        rw(1'b0, PC_OFS, 32'h0, q);
        `CHK("pc_rst", 12'h000, q[11:0])
        // Unmapped place answers with an error and zero data
        u_host.xfer(1'b0, 8'h20, 32'h0, q, e, ok);
        `CHK("unmapped_err", 1'b1, e)
        `CHK("unmapped_data", 32'h0, q)
        `CHK("unmapped_ok", 1'b1, ok)
        // Random data instructions, with carry and overflow corners on the add
        for (int i = 0; i < 24; i++) begin
            a = 8'($urandom);
            m = 8'($urandom);
            f = 5'($urandom);
            pcv = 12'($urandom);
            c = cmd_s'($urandom);
            c.op = op_e'(ops[i % 8]);
            if (i == 1) begin
                a = 8'h7F;
                m = 8'h01;
            end
            if (i == 9) begin
                a = 8'h80;
                m = 8'h80;
            end
            ma = MEM_OFS + {2'b00, c.addr, 2'b00};
            rw(1'b1, ACC_OFS, {24'h0, a}, q);
            rw(1'b1, ma, {24'h0, m}, q);
            rw(1'b1, STAT_OFS, {27'h0, f}, q);
            rw(1'b1, PC_OFS, {20'h0, pcv}, q);
            rw(1'b1, CMD_OFS, c, q);
            model(c.op, c.target[7:0], c.bit_sel, a, m, f);
            rw(1'b0, ACC_OFS, 32'h0, q);
            `CHK("acc", a, q[7:0])
            rw(1'b0, ma, 32'h0, q);
            `CHK("mem", m, q[7:0])
            rw(1'b0, STAT_OFS, 32'h0, q);
            `CHK("flags", f, q[4:0])
            rw(1'b0, PC_OFS, 32'h0, q);
            `CHK("pc_step", pcv + PC_STEP, q[11:0])
        end
        // Call from the top of program space, flags must survive
        c = cmd_s'($urandom);
        c.op = OP_CALL;
        f = 5'($urandom);
        rw(1'b1, STAT_OFS, {27'h0, f}, q);
        rw(1'b1, PC_OFS, 32'h0000_0FFF, q);
        rw(1'b1, CMD_OFS, c, q);
        @(posedge clock);
        `CHK("call_busy_on", 1'b1, call_busy)
        @(posedge clock);
        `CHK("call_busy_off", 1'b0, call_busy)
        rw(1'b0, PC_OFS, 32'h0, q);
        `CHK("call_target", c.target, q[11:0])
        rw(1'b0, STAT_OFS, 32'h0, q);
        `CHK("call_flags", f, q[4:0])
        // Sleep pin plus watchdog expiry, then the restart instruction
        sleep_enter <= 1'b1;
        repeat (400) @(posedge clock);
        rw(1'b0, STAT_OFS, 32'h0, q);
        `CHK("flags_set", 2'b11, q[6:5])
        c = '0;
        c.op = OP_WDT_RESTART;
        rw(1'b1, CMD_OFS, c, q);
        rw(1'b0, STAT_OFS, 32'h0, q);
        `CHK("flags_clear", 2'b00, q[6:5])
        `CHK("flags_kept", f, q[4:0])
        rw(1'b0, WDT_OFS, 32'h0, q);
        `CHK("wdt_restart", 1'b1, q[15:0] <= 16'h0001)
        sleep_enter <= 1'b0;
        report_and_stop();
    end
endmodule
`default_nettype wire
